// ===== inc/halt_or_pkg.sv
// Package for the core-halt and inclusive-OR execution block.
// Assumes a single core clock domain and no software-visible registers.
package halt_or_pkg;
  // ==========================================================================
  // Widths and reset values
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic HALT_RESET = 1'b0;
  localparam logic [7:0] WRITE_RESET = 8'h00;
  // Destination select encodings
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_MEM = 1'b1;
  // Number of cycles each OR instruction takes
  localparam int OR_CYCLES = 1;
  // ==========================================================================
  // Operation codes presented by the decoder
  typedef enum logic [1:0] {
    op_none,
    op_halt,
    or_literal_into_acc,
    or_acc_with_memory
  } op_t;
endpackage : halt_or_pkg

// ===== rtl/or_unit.sv
// Combinational inclusive-OR unit with zero detection.
// Assumes operands are stable within one core clock cycle.
`timescale 1ns/1ps
`default_nettype none
module or_unit (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] result,
  output logic zero
);
  // ==========================================================================
  // Bitwise OR and all-zero detect
  assign result = a | b;
  assign zero = (result == 8'h00);
endmodule : or_unit
`default_nettype wire

// ===== rtl/halt_or_exec.sv
// Execution of the core-halt instruction and the two inclusive-OR instructions.
// Assumes a decoder presents one op per cycle while the core clock runs, and
// that data memory answers a read combinationally on mem_rdata.
// Results show one edge after the taking edge; nothing is buffered.
`timescale 1ns/1ps
`default_nettype none
module halt_or_exec (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire halt_or_pkg::op_t op,
  input wire logic [7:0] literal,
  input wire logic [7:0] mem_addr,
  input wire logic dest_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic int_internal,
  input wire logic int_external,
  output logic core_clock_en,
  output logic osc_run,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic mem_we,
  output logic [7:0] mem_waddr,
  output logic [7:0] mem_wdata
);
  // ==========================================================================
  // State
  // Everything the block remembers sits in one record: the halt latch, the
  // accumulator and zero flag, the registered write port and the two stages
  // that carry the interrupt pin into the core clock domain.
  typedef struct packed {
    logic halted;
    logic [7:0] acc;
    logic zero;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic ext_meta;
    logic ext_sync;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [7:0] or_a;
  logic [7:0] or_b;
  logic [7:0] or_res;
  logic or_zero;
  logic wake;

  // Operand select: the immediate or the memory byte
  // One shared OR path serves both instructions; mem_rdata must settle within
  // the cycle, since there is no read register in front of it.
  assign or_a = cur.acc;
  assign or_b = (op == halt_or_pkg::or_literal_into_acc) ? literal : mem_rdata;

  // Shared OR and zero detect
  or_unit i_or_unit (
    .a(or_a),
    .b(or_b),
    .result(or_res),
    .zero(or_zero)
  );

  // ==========================================================================
  // Wake sources
  // External pin is synchronised; internal sources share the core clock
  // Only the second stage is read, so a metastable first stage never reaches
  // the halt latch; the cost is two extra edges of wake latency on the pin.
  // Wake is level sensitive, so a source held high ends any halt one edge after the halt is taken.
  assign wake = int_internal | cur.ext_sync;

  // ==========================================================================
  // Next state
  // Halt is only set while running and only cleared while halted, so a set
  // and a clear can never meet in one cycle. The write strobe drops by
  // default, which makes it a one-cycle pulse per memory-destination OR.
  always_comb begin
    next_cur = cur;
    next_cur.ext_meta = int_external;
    next_cur.ext_sync = cur.ext_meta;
    next_cur.we = 1'b0;
    if (cur.halted) begin
      // Ops are ignored while halted; only an interrupt or a reset restarts the core
      if (wake) begin
        next_cur.halted = 1'b0;
      end
    end else if (op_valid) begin
      // Only a running core takes an op; op_none falls to the default
      case (op)
        halt_or_pkg::op_halt: begin
          next_cur.halted = 1'b1;
        end
        halt_or_pkg::or_literal_into_acc: begin
          next_cur.acc = or_res;
          next_cur.zero = or_zero;
        end
        halt_or_pkg::or_acc_with_memory: begin
          // Zero follows the result whichever way the destination points
          next_cur.zero = or_zero;
          if (dest_sel == halt_or_pkg::DEST_ACC) begin
            next_cur.acc = or_res;
          end else begin
            next_cur.we = 1'b1;
            next_cur.waddr = mem_addr;
            next_cur.wdata = or_res;
          end
        end
        default: begin
          next_cur.halted = cur.halted;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // Reset releases the core running, so a halt never survives a reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{halted: halt_or_pkg::HALT_RESET, acc: halt_or_pkg::ACC_RESET,
               zero: halt_or_pkg::ZERO_RESET, we: 1'b0, waddr: halt_or_pkg::WRITE_RESET,
               wdata: halt_or_pkg::WRITE_RESET, ext_meta: 1'b0, ext_sync: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Outputs
  // All data outputs come straight from the state record; the clock enable
  // is the inverted halt latch, so it carries no glitch into the clock gate.
  assign core_clock_en = ~cur.halted;
  // This block never stops the oscillator; only the sleep path may do that
  assign osc_run = 1'b1;
  assign acc = cur.acc;
  assign zero_flag = cur.zero;
  assign mem_we = cur.we;
  assign mem_waddr = cur.waddr;
  assign mem_wdata = cur.wdata;

  // ==========================================================================
  // Checks
  // Every property samples on the core clock and is off while reset is low.
  // Antecedents name the taking edge, so a halted core never arms the OR
  // checks, and expected values are rebuilt from sampled inputs.

  // Halt taken: core stops next cycle, oscillator keeps going
  halt_stops_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::op_halt) |=> !core_clock_en && osc_run)
    else $error("halt did not stop core clock");

  // Only a taken halt may stop a running core
  run_steady_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && !(op_valid && op == halt_or_pkg::op_halt)) |=> core_clock_en)
    else $error("core stopped without a halt");

  // Internal source wakes in one edge, it shares the core clock
  wake_resume_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cur.halted && int_internal) |=> core_clock_en)
    else $error("interrupt did not resume core clock");

  // External source wakes once it has crossed both sync stages;
  // the first stage alone must never be enough
  ext_wake_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cur.halted && cur.ext_sync) |=> core_clock_en)
    else $error("synchronised pin did not resume core clock");

  // No interrupt, no wake
  halt_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (cur.halted && !wake) |=> !core_clock_en)
    else $error("core woke without interrupt");

  // Ops presented while halted leave every result untouched,
  // the wake edge included
  halt_ignore_a: assert property (@(posedge clock) disable iff (!rst_b)
    cur.halted |=> !mem_we && $stable(acc) && $stable(zero_flag))
    else $error("op executed while halted");

  // Literal OR: accumulator and zero take the result, memory is never written
  lit_or_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_literal_into_acc)
      |=> acc == ($past(acc) | $past(literal)))
    else $error("literal OR result wrong");
  lit_no_write_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_literal_into_acc) |=> !mem_we)
    else $error("literal OR wrote memory");
  lit_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_literal_into_acc)
      |=> zero_flag == (($past(acc) | $past(literal)) == 8'h00))
    else $error("literal OR zero flag wrong");

  // Memory OR: zero follows the result for either destination
  mem_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_acc_with_memory)
      |=> zero_flag == (($past(acc) | $past(mem_rdata)) == 8'h00))
    else $error("memory OR zero flag wrong");

  // Destination 0: accumulator takes the result, no write strobe
  dest_acc_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_acc_with_memory && !dest_sel)
      |=> !mem_we && acc == ($past(acc) | $past(mem_rdata)))
    else $error("dest 0 result misplaced");

  // Destination 1: one write to the operand's own address,
  // accumulator left as it was
  dest_mem_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && op_valid && op == halt_or_pkg::or_acc_with_memory && dest_sel)
      |=> mem_we && $stable(acc) && mem_waddr == $past(mem_addr)
        && mem_wdata == ($past(acc) | $past(mem_rdata)))
    else $error("dest 1 result misplaced");

  // Nothing taken: results hold and no write strobe leaks out,
  // so each OR finishes within its own cycle
  idle_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!cur.halted && (!op_valid || op == halt_or_pkg::op_none))
      |=> $stable(acc) && $stable(zero_flag) && !mem_we)
    else $error("results moved with no op taken");
endmodule : halt_or_exec
`default_nettype wire

// ===== sim/halt_or_exec_tb.sv
// Bench for the core-halt and inclusive-OR execution block.
// Assumes halt_or_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module halt_or_exec_tb;
  // ==========================================================================
  // Stimulus, observed outputs and counters
  localparam halt_or_pkg::op_t lit_or = halt_or_pkg::or_literal_into_acc;
  localparam halt_or_pkg::op_t mem_or = halt_or_pkg::or_acc_with_memory;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  halt_or_pkg::op_t op = halt_or_pkg::op_none;
  logic [7:0] literal = 8'h00;
  logic [7:0] mem_addr = 8'h10;
  logic dest_sel = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic int_internal = 1'b0;
  logic int_external = 1'b0;
  logic core_clock_en, osc_run, zero_flag, mem_we;
  logic [7:0] acc, mem_waddr, mem_wdata;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Row: op, dest, operand, expected acc, zero, write strobe, write data
  typedef struct packed {
    halt_or_pkg::op_t op;
    logic d;
    logic [7:0] din;
    logic [7:0] acc;
    logic z;
    logic we;
    logic [7:0] wd;
  } row_t;
  // Ops run back to back; acc starts at 00 so the first row hits zero
  localparam row_t rows[6] = '{
    '{mem_or, 1'b1, 8'h00, 8'h00, 1'b1, 1'b1, 8'h00},
    '{lit_or, 1'b0, 8'h85, 8'h85, 1'b0, 1'b0, 8'h00},
    '{lit_or, 1'b0, 8'h69, 8'hed, 1'b0, 1'b0, 8'h00},
    '{mem_or, 1'b1, 8'h23, 8'hed, 1'b0, 1'b1, 8'hef},
    '{mem_or, 1'b0, 8'h12, 8'hff, 1'b0, 1'b0, 8'h00},
    '{halt_or_pkg::op_none, 1'b0, 8'h00, 8'hff, 1'b0, 1'b0, 8'h00}};
  halt_or_exec i_halt_or_exec (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op(op),
    .literal(literal), .mem_addr(mem_addr), .dest_sel(dest_sel), .mem_rdata(mem_rdata),
    .int_internal(int_internal), .int_external(int_external), .core_clock_en(core_clock_en),
    .osc_run(osc_run), .acc(acc), .zero_flag(zero_flag), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
  // ==========================================================================
  // Clock, shared tasks and hang guard
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so they never race the sampling edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic end_of_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // Run needs about 20 cycles, so 500 means a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 500) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================================
  // Reset, table loop, halt and wake, mid-run reset
  initial begin
    repeat (3) tick();
    chk("acc_rst", 8'h00, acc);
    chk("en_rst", 8'h01, {7'h00, core_clock_en});
    rst_b = 1'b1;
    op_valid = 1'b1;
    foreach (rows[i]) begin
      op = rows[i].op;
      dest_sel = rows[i].d;
      literal = rows[i].din;
      mem_rdata = rows[i].din;
      mem_addr = 8'h10 + 8'(i);
      tick();
      chk("acc", rows[i].acc, acc);
      chk("zero", {7'h00, rows[i].z}, {7'h00, zero_flag});
      chk("we", {7'h00, rows[i].we}, {7'h00, mem_we});
      chk("wdata", rows[i].wd, rows[i].we ? mem_wdata : 8'h00);
      if (rows[i].we) chk("waddr", 8'h10 + 8'(i), mem_waddr);
    end
    op = halt_or_pkg::op_halt;
    tick();
    chk("halted", 8'h00, {7'h00, core_clock_en});
    chk("osc", 8'h01, {7'h00, osc_run});
    op = mem_or;
    dest_sel = 1'b1;
    tick();
    chk("we_halt", 8'h00, {7'h00, mem_we});
    int_internal = 1'b1;
    tick();
    int_internal = 1'b0;
    chk("wake_int", 8'h01, {7'h00, core_clock_en});
    op = halt_or_pkg::op_halt;
    tick();
    op = halt_or_pkg::op_none;
    int_external = 1'b1;
    repeat (2) tick();
    chk("sync_wait", 8'h00, {7'h00, core_clock_en});
    tick();
    chk("wake_ext", 8'h01, {7'h00, core_clock_en});
    // Halt again, then reset while halted: the core must come back running
    op = halt_or_pkg::op_halt;
    tick();
    op = halt_or_pkg::op_none;
    chk("halt2", 8'h00, {7'h00, core_clock_en});
    rst_b = 1'b0;
    #1;
    chk("acc_rst2", 8'h00, acc);
    chk("en_rst2", 8'h01, {7'h00, core_clock_en});
    chk("we_rst2", 8'h00, {7'h00, mem_we});
    tick();
    // First op after release is taken at the first edge
    rst_b = 1'b1;
    op = lit_or;
    literal = 8'h00;
    tick();
    chk("acc_rel", 8'h00, acc);
    chk("zero_rel", 8'h01, {7'h00, zero_flag});
    end_of_test();
  end
endmodule : halt_or_exec_tb
`default_nettype wire
